// *** src/bsr_map.vh ***
`ifndef BSR_MAP_VH
`define BSR_MAP_VH
// -----------------------------------------------------------------
// Framing
// -----------------------------------------------------------------
`define BSR_START_BITS    3'h3
`define BSR_STOP_BITS     3'h3
`define BSR_SETUP_BITS    4'h4
`define BSR_FRAME_BITS    4'ha
`define BSR_RESET_BITS    5'h15
`define BSR_RESET_PATTERN 21'h155540
// -----------------------------------------------------------------
// Setup codes
// -----------------------------------------------------------------
`define BSR_CODE_PRES     4'ha
`define BSR_CODE_TEMP     4'h9
`define BSR_CODE_CAL1     4'h5
`define BSR_CODE_CAL2     4'h6
`define BSR_CODE_CAL3     4'h3
`define BSR_CODE_CAL4     4'hc
// -----------------------------------------------------------------
// Sequence positions and conversion timing
// -----------------------------------------------------------------
`define BSR_ACK_EXTRA     2'h2
`define BSR_READ_BITS     5'h11
`define BSR_WORD_BITS     5'h10
`define BSR_CONV_TIME_US  35000
`define BSR_CLK_MHZ       10
`define BSR_CONV_CYCLES   (`BSR_CONV_TIME_US * `BSR_CLK_MHZ)
// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define BSR_CAL_RESET     64'h0000000000000000
`endif

// *** src/bsr_buf2.v ***
`timescale 1ns/1ps
`default_nettype none
module bsr_buf2 (
   // Clock and reset
   input  wire        clock_in,
   input  wire        rst_in,
   // Fill side
   input  wire        in_valid_in,
   output wire        in_ready_out,
   input  wire [15:0] in_data_in,
   // Drain side
   output wire        out_valid_out,
   input  wire        out_ready_in,
   output wire [15:0] out_data_out
);
   reg  [15:0] mem_reg [0:1];
   reg         wr_ptr_reg;
   reg         rd_ptr_reg;
   reg  [1:0]  count_reg;
   wire        push;
   wire        pop;

   assign in_ready_out  = (count_reg != 2'h2);
   assign out_valid_out = (count_reg != 2'h0);
   assign out_data_out  = mem_reg[rd_ptr_reg];
   assign push          = in_valid_in & in_ready_out;
   assign pop           = out_valid_out & out_ready_in;

   always @(posedge clock_in) begin
      if (push) begin
         mem_reg[wr_ptr_reg] <= in_data_in;
      end
   end

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg  <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         if (push & ~pop) begin
            count_reg <= count_reg + 2'h1;
         end else if (pop & ~push) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end
endmodule // bsr_buf2
`default_nettype wire

// *** src/bsr_readout.v ***
// Function
// - Sample each input bit on rising serial clock edges.
// - Change the output bit on rising serial clock edges.
// - Latest instruction chooses result or calibration word output.
// - No select pin; instruction bits alone frame each transaction.
// - Instruction is three high bits, setup field, three low bits.
// - Four-bit setup field picks pressure, temperature or calibration word.
// - Seven operations: two conversions, four calibration reads, reset.
// - Output rises low to high once a conversion is accepted.
// - Output falls high to low when the conversion is done.
// - Seventeen clocks after completion carry the sixteen-bit result.
// - Clock pause holds readout position; shifting resumes afterwards.
// - Reset pattern seen in any state returns the port to idle.
// - Reset pattern is 21 bits; output may toggle meanwhile.
// - Calibration words pack six coefficients as documented.
// - Calibration store is 64 bits, read as four 16-bit words.
// - Both conversions give a 16-bit value from one converter.
`timescale 1ns/1ps
`default_nettype none
`include "bsr_map.vh"
module bsr_readout #(
   parameter [31:0] CONV_CYCLES = `BSR_CONV_CYCLES
) (
   // Clock and reset
   input  wire        clock_in,
   input  wire        rst_in,
   // Serial pins
   input  wire        sclk_in,
   input  wire        din_in,
   output wire        dout_out,
   // Converter side
   output wire        conv_start_out,
   output wire        conv_is_temp_out,
   input  wire        conv_valid_in,
   output wire        conv_ready_out,
   input  wire [15:0] conv_data_in,
   // Calibration store
   input  wire [63:0] cal_data_in
);
   // ---------------------------------------------------------------
   // States
   // ---------------------------------------------------------------
   localparam [4:0] ST_CMD  = 5'h01;
   localparam [4:0] ST_ACK  = 5'h02;
   localparam [4:0] ST_CONV = 5'h04;
   localparam [4:0] ST_READ = 5'h08;
   localparam [4:0] ST_CAL  = 5'h10;

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   reg         sclk_s1_reg;
   reg         sclk_s2_reg;
   reg         sclk_s3_reg;
   reg         din_s1_reg;
   reg         din_s2_reg;
   wire        rise;

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         sclk_s1_reg <= 1'b0;
         sclk_s2_reg <= 1'b0;
         sclk_s3_reg <= 1'b0;
         din_s1_reg  <= 1'b0;
         din_s2_reg  <= 1'b0;
      end else begin
         sclk_s1_reg <= sclk_in;
         sclk_s2_reg <= sclk_s1_reg;
         sclk_s3_reg <= sclk_s2_reg;
         din_s1_reg  <= din_in;
         din_s2_reg  <= din_s1_reg;
      end
   end

   // Only rising edges matter; the host owns the clock
   assign rise = sclk_s2_reg & ~sclk_s3_reg;

   // ---------------------------------------------------------------
   // Result buffer
   // ---------------------------------------------------------------
   wire        buf_valid;
   reg         buf_pop;
   wire [15:0] buf_data;

   bsr_buf2 u_buf (
      .clock_in      (clock_in),
      .rst_in        (rst_in),
      .in_valid_in   (conv_valid_in),
      .in_ready_out  (conv_ready_out),
      .in_data_in    (conv_data_in),
      .out_valid_out (buf_valid),
      .out_ready_in  (buf_pop),
      .out_data_out  (buf_data)
   );

   // ---------------------------------------------------------------
   // Protocol engine
   // ---------------------------------------------------------------
   reg  [4:0]  state_reg;
   reg  [4:0]  state_next;
   reg  [9:0]  frame_reg;
   reg  [20:0] rst_shift_reg;
   reg  [4:0]  cnt_reg;
   reg  [4:0]  cnt_next;
   reg  [15:0] out_sh_reg;
   reg  [15:0] out_sh_next;
   reg         dout_reg;
   reg         dout_next;
   reg         start_reg;
   reg         start_next;
   reg         temp_reg;
   reg         temp_next;
   reg  [31:0] wait_reg;
   reg  [31:0] wait_next;
   wire [9:0]  frame_new;
   wire [20:0] rst_new;
   wire [3:0]  code;
   wire        frame_ok;
   wire        reset_hit;
   reg  [15:0] cal_word;
   reg         cal_hit;

   assign frame_new = {frame_reg[8:0], din_s2_reg};
   assign rst_new   = {rst_shift_reg[19:0], din_s2_reg};
   // Setup codes come from the map header, so they can be retuned
   assign code      = frame_new[6:3];
   // Start field high, stop field low
   assign frame_ok  = (frame_new[9:7] == 3'h7) & (frame_new[2:0] == 3'h0);
   assign reset_hit = (rst_new == `BSR_RESET_PATTERN);

   // Words are stored packed; coefficient split is the store's
   always @* begin
      cal_word = 16'h0000;
      cal_hit  = 1'b1;
      case (code)
         `BSR_CODE_CAL1: cal_word = cal_data_in[63:48];
         `BSR_CODE_CAL2: cal_word = cal_data_in[47:32];
         `BSR_CODE_CAL3: cal_word = cal_data_in[31:16];
         `BSR_CODE_CAL4: cal_word = cal_data_in[15:0];
         default:        cal_hit  = 1'b0;
      endcase
   end

   always @* begin
      state_next  = state_reg;
      cnt_next    = cnt_reg;
      out_sh_next = out_sh_reg;
      dout_next   = dout_reg;
      start_next  = 1'b0;
      temp_next   = temp_reg;
      wait_next   = wait_reg;
      buf_pop     = 1'b0;
      if (rise & reset_hit) begin
         // Reset wins in every state; dout may have toggled
         state_next = ST_CMD;
         cnt_next   = 5'h00;
         dout_next  = 1'b0;
      end else begin
         case (state_reg)
            ST_CMD: begin
               if (rise & frame_ok) begin
                  // Latest instruction picks what comes out
                  if ((code == `BSR_CODE_PRES) | (code == `BSR_CODE_TEMP)) begin
                     temp_next  = (code == `BSR_CODE_TEMP);
                     start_next = 1'b1;
                     dout_next  = 1'b1;
                     cnt_next   = 5'h00;
                     wait_next  = 32'h00000000;
                     state_next = ST_ACK;
                  end else if (cal_hit) begin
                     out_sh_next = cal_word;
                     cnt_next    = 5'h00;
                     state_next  = ST_CAL;
                  end
               end
            end
            ST_ACK: begin
               // Two trailing clocks after acknowledge
               if (rise) begin
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg[1:0] == (`BSR_ACK_EXTRA - 2'h1)) begin
                     state_next = ST_CONV;
                  end
               end
            end
            ST_CONV: begin
               if (wait_reg < CONV_CYCLES) begin
                  wait_next = wait_reg + 32'h00000001;
               end
               // Result only taken once the minimum time elapsed
               if (buf_valid & (wait_reg >= CONV_CYCLES)) begin
                  buf_pop     = 1'b1;
                  out_sh_next = buf_data;
                  dout_next   = 1'b0;
                  cnt_next    = 5'h00;
                  state_next  = ST_READ;
               end
            end
            ST_READ, ST_CAL: begin
               // No edge, no move: a clock pause holds position
               if (rise) begin
                  cnt_next = cnt_reg + 5'h01;
                  if (cnt_reg < `BSR_WORD_BITS) begin
                     dout_next   = out_sh_reg[15];
                     out_sh_next = {out_sh_reg[14:0], 1'b0};
                  end else begin
                     dout_next = 1'b0;
                  end
                  if (cnt_next == `BSR_READ_BITS) begin
                     state_next = ST_CMD;
                  end
               end
            end
            default: begin
               state_next = ST_CMD;
            end
         endcase
      end
   end

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg     <= ST_CMD;
         frame_reg     <= 10'h000;
         rst_shift_reg <= 21'h000000;
         cnt_reg       <= 5'h00;
         out_sh_reg    <= 16'h0000;
         dout_reg      <= 1'b0;
         start_reg     <= 1'b0;
         temp_reg      <= 1'b0;
         wait_reg      <= 32'h00000000;
      end else begin
         if (rise) begin
            // Framing restarts after a complete instruction
            frame_reg     <= (state_reg == ST_CMD && frame_ok) ? 10'h000 : frame_new;
            rst_shift_reg <= rst_new;
         end
         state_reg  <= state_next;
         cnt_reg    <= cnt_next;
         out_sh_reg <= out_sh_next;
         dout_reg   <= dout_next;
         start_reg  <= start_next;
         temp_reg   <= temp_next;
         wait_reg   <= wait_next;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign dout_out         = dout_reg;
   assign conv_start_out   = start_reg;
   assign conv_is_temp_out = temp_reg;
endmodule // bsr_readout
`default_nettype wire

// *** verif/bsr_readout_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bsr_map.vh"
module bsr_readout_asserts (
   // Port signals watched
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic sclk_in,
   input wire logic din_in,
   input wire logic dout_out,
   input wire logic conv_start_out,
   input wire logic conv_is_temp_out,
   input wire logic conv_valid_in,
   input wire logic conv_ready_out
);
   // ---------------------------------------------------------------
   // Serial rise seen as the port does: two sync flops and an edge flop
   // ---------------------------------------------------------------
   function automatic logic [9:0] fr(input logic [3:0] c);
      return {3'h7, c, 3'h0};
   endfunction
   logic [2:0] s_reg;
   logic [1:0] d_reg;
   logic [9:0] sh_reg;
   wire logic  rise_det = s_reg[1] & ~s_reg[2];
   wire logic  cal_hit  = sh_reg == fr(`BSR_CODE_CAL1) || sh_reg == fr(`BSR_CODE_CAL2) ||
                          sh_reg == fr(`BSR_CODE_CAL3) || sh_reg == fr(`BSR_CODE_CAL4);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         s_reg  <= 3'h0;
         d_reg  <= 2'h0;
         sh_reg <= 10'h000;
      end else begin
         s_reg <= {s_reg[1:0], sclk_in};
         d_reg <= {d_reg[0], din_in};
         if (rise_det) sh_reg <= {sh_reg[8:0], d_reg[1]};
      end
   end
   a_start_pulse: assert property (conv_start_out |=> !conv_start_out [*8])
      else $error("conversion start not a lone pulse");
   a_start_edge: assert property (conv_start_out |-> $past(rise_det))
      else $error("conversion start without a serial rise");
   a_start_code: assert property (conv_start_out |->
      (sh_reg == fr(`BSR_CODE_PRES) && !conv_is_temp_out) ||
      (sh_reg == fr(`BSR_CODE_TEMP) && conv_is_temp_out)) else $error("start for wrong frame");
   a_cal_quiet: assert property ($past(rise_det) && cal_hit |->
      !conv_start_out && !$rose(dout_out)) else $error("calibration frame acknowledged");
   a_ack_holds: assert property (conv_start_out |-> dout_out [*8])
      else $error("acknowledge level dropped early");
   a_dout_rise: assert property ($rose(dout_out) |-> $past(rise_det))
      else $error("output rose off a serial rise");
   a_dout_stable: assert property (sclk_in && !$past(rise_det) |-> $stable(dout_out))
      else $error("output moved while clock high");
   a_ready_fall: assert property ($fell(conv_ready_out) |->
      $past(conv_valid_in && conv_ready_out)) else $error("buffer full without a word");
endmodule // bsr_readout_asserts
`default_nettype wire

// *** verif/bsr_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bsr_host_model (
   // Pins
   input  wire logic clk_in,
   input  wire logic dout_in,
   output var  logic sclk_out,
   output var  logic din_out
);
   // ---------------------------------------------------------------
   // Host side: sole clock source, clock stands low between frames
   // ---------------------------------------------------------------
   initial begin
      sclk_out = 1'b0;
      din_out  = 1'b0;
   end
   // New input bit at the fall, output sampled at the fall
   task automatic bit_x(input logic b, output logic o);
      din_out = b;
      repeat (4) @(posedge clk_in);
      #1 sclk_out = 1'b1;
      repeat (4) @(posedge clk_in);
      #1 o = dout_in;
      sclk_out = 1'b0;
   endtask
   // Msb first; a pause holds the clock low, kept a whole number of cycles
   task automatic shift(input logic [31:0] v, input int n, input int p,
                        output logic [31:0] g);
      logic o;
      g = 32'h0;
      for (int i = n - 1; i >= 0; i--) begin
         if (i == p) #6000;
         bit_x(v[i], o);
         g = {g[30:0], o};
      end
   endtask
endmodule // bsr_host_model
`default_nettype wire

// *** verif/test_barometer_serial_readout.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bsr_map.vh"
module test_barometer_serial_readout;
   logic        clock_in, rst_in, sclk, din, dout, start, is_temp, ready, conv_valid;
   logic [15:0] conv_data;
   logic [63:0] cal_data;
   logic [15:0] feed_q[$], exp_q[$];
   logic [31:0] g;
   int          num_errors, checks, seed;
   bsr_readout #(.CONV_CYCLES(32'h14)) i_dut (.clock_in(clock_in), .rst_in(rst_in),
      .sclk_in(sclk), .din_in(din), .dout_out(dout), .conv_start_out(start),
      .conv_is_temp_out(is_temp), .conv_valid_in(conv_valid), .conv_ready_out(ready),
      .conv_data_in(conv_data), .cal_data_in(cal_data));
   bsr_host_model i_host (.clk_in(clock_in), .dout_in(dout), .sclk_out(sclk), .din_out(din));
   initial begin
      clock_in = 1'b0;
      forever #50 clock_in = ~clock_in;
   end
   // ---------------------------------------------------------------
   // Converter: queued words, sometimes late, held until taken
   // ---------------------------------------------------------------
   initial begin
      conv_valid = 1'b0;
      conv_data  = 16'h0000;
      forever begin
         @(posedge clock_in);
         if (feed_q.size() != 0) begin
            repeat ($urandom_range(3)) @(posedge clock_in);
            #1 conv_valid = 1'b1;
            conv_data = feed_q[0];
            while (ready !== 1'b1) begin
               @(posedge clock_in);
               #1;
            end
            @(posedge clock_in);
            #1 conv_valid = 1'b0;
            conv_data = ~conv_data;
            void'(feed_q.pop_front());
         end
      end
   end
   task automatic chk_bit(input logic got, input logic exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t bit %b expected %b", $time, got, exp);
      end
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic end_of_test;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   function automatic logic [31:0] fr(input logic [3:0] c);
      return {22'h0, 3'h7, c, 3'h0};
   endfunction
   task automatic push;
      logic [15:0] w;
      w = 16'($urandom);
      feed_q.push_back(w);
      exp_q.push_back(w);
   endtask
   task automatic cal_op(input int k);
      logic [3:0] c;
      c = k == 0 ? `BSR_CODE_CAL1 : k == 1 ? `BSR_CODE_CAL2 : k == 2 ? `BSR_CODE_CAL3 : `BSR_CODE_CAL4;
      i_host.shift(fr(c), 10, -1, g);
      i_host.shift(32'h0, 17, -1, g);
      chk_word(g[16:1], cal_data[63 - 16 * k -: 16]);
   endtask
   // Reset pattern, frame, acknowledge, completion, then nr readout clocks
   task automatic conv_op(input logic [3:0] c, input int p, input int nr);
      logic [15:0] e;
      int          n;
      i_host.shift({11'h0, `BSR_RESET_PATTERN}, 21, -1, g);
      i_host.shift(fr(c), 10, -1, g);
      chk_bit(g[0], 1'b1);
      chk_bit(is_temp, c == `BSR_CODE_TEMP);
      i_host.shift(32'h0, 2, -1, g);
      n = 0;
      while (dout !== 1'b0 && n < 2000) begin
         @(posedge clock_in);
         n++;
      end
      #1 chk_bit(dout, 1'b0);
      i_host.shift(32'h0, nr, p, g);
      e = exp_q.pop_front();
      if (nr == 17) chk_word(g[16:1], e);
      else chk_word(g[15:0], e >> (16 - nr));
   endtask
   initial begin
      seed = $urandom(32'ha3ca);
      num_errors = 0;
      checks = 0;
      cal_data = {$urandom(), $urandom()};
      rst_in = 1'b1;
      repeat (3) @(posedge clock_in);
      #1 rst_in = 1'b0;
      repeat (3) @(posedge clock_in);
      #1;
      for (int k = 0; k < 4; k++) cal_op(k);
      // Refused frames: bad stop field, unknown setup code
      i_host.shift({22'h0, 3'h7, `BSR_CODE_PRES, 3'h1}, 10, -1, g);
      chk_bit(g[0], 1'b0);
      i_host.shift(fr(4'h0), 10, -1, g);
      chk_bit(g[0], 1'b0);
      for (int k = 0; k < 4; k++) begin
         push();
         conv_op(k[0] ? `BSR_CODE_TEMP : `BSR_CODE_PRES, k == 1 ? 8 : -1, 17);
      end
      // Three words before any conversion: the buffer refuses the third
      repeat (3) push();
      repeat (30) @(posedge clock_in);
      #1 chk_bit(ready, 1'b0);
      repeat (3) conv_op(`BSR_CODE_PRES, -1, 17);
      chk_bit(ready, 1'b1);
      // Reset pattern cuts a readout and a half frame short
      push();
      conv_op(`BSR_CODE_TEMP, -1, 6);
      i_host.shift({11'h0, `BSR_RESET_PATTERN}, 21, -1, g);
      cal_op(2);
      i_host.shift(32'h1d, 5, -1, g);
      i_host.shift({11'h0, `BSR_RESET_PATTERN}, 21, -1, g);
      cal_op(1);
      end_of_test();
   end
   initial begin
      #2000000;
      num_errors++;
      $display("BAD %0t watchdog expired", $time);
      end_of_test();
   end
endmodule // test_barometer_serial_readout
bind bsr_readout bsr_readout_asserts i_chk (.clock_in, .rst_in, .sclk_in, .din_in, .dout_out,
   .conv_start_out, .conv_is_temp_out, .conv_valid_in, .conv_ready_out);
`default_nettype wire
